// ---- pldl_pkg.sv ----
// Package with register map, field layout, reset values, timing figures and carrier structs of the lock detector.
package pldl_pkg;

   // Register bus geometry and answers.
   localparam int          AXIL_AW         = 12;
   localparam logic [1:0]  RESP_OKAY       = 2'h0;
   localparam logic [1:0]  RESP_SLVERR     = 2'h2;

   // Register byte addresses.
   localparam logic [11:0] ADDR_LOCK_CFG   = 12'h018;
   localparam logic [11:0] ADDR_PULSE_CFG  = 12'h01c;
   localparam logic [11:0] ADDR_STATUS     = 12'h020;
   localparam logic [11:0] ADDR_IRQ_STAT   = 12'h024;
   localparam logic [11:0] ADDR_IRQ_MASK   = 12'h028;

   // Field positions of lock_detect_config, detector_pulse_config, the status register and the interrupt registers.
   localparam int          LCFG_DC_OFS_BIT = 7;
   localparam int          LCFG_CNT_LSB    = 5;
   localparam int          LCFG_WIN_BIT    = 4;
   localparam int          PCFG_ABL_LSB    = 0;
   localparam int          STAT_CNT_LSB    = 8;
   localparam int          IRQ_LOCK_BIT    = 0;
   localparam int          IRQ_LOSS_BIT    = 1;

   // Reset values; only the window select is set, choosing the high range.
   localparam logic [7:0]  LCFG_RESET      = 8'h10;
   localparam logic [7:0]  LCFG_RW_MASK    = 8'hf0;
   localparam logic [7:0]  PCFG_RESET      = 8'h00;
   localparam logic [7:0]  PCFG_RW_MASK    = 8'h03;
   localparam logic [1:0]  IRQ_RESET       = 2'h0;

   // Antibacklash pulse widths in picoseconds.
   localparam logic [15:0] ABL_PS_2P9      = 16'h0b54;
   localparam logic [15:0] ABL_PS_1P3      = 16'h0514;
   localparam logic [15:0] ABL_PS_6P0      = 16'h1770;

   // Consecutive in-window detector cycles needed for lock.
   localparam logic [7:0]  LOCK_RUN_5      = 8'h05;
   localparam logic [7:0]  LOCK_RUN_16     = 8'h10;
   localparam logic [7:0]  LOCK_RUN_64     = 8'h40;
   localparam logic [7:0]  LOCK_RUN_255    = 8'hff;

   // Timing figures in picoseconds; DIFF_MAX is the largest edge spacing in cycles.
   localparam int          CLK_PERIOD_PS   = 20000;
   localparam int          WIN_HIGH_PS     = 3500;
   localparam logic [7:0]  DIFF_MAX        = 8'hff;

   typedef struct packed {
      logic               awvalid;
      logic [AXIL_AW-1:0] awaddr;
      logic               wvalid;
      logic [31:0]        wdata;
      logic [3:0]         wstrb;
      logic               bready;
      logic               arvalid;
      logic [AXIL_AW-1:0] araddr;
      logic               rready;
   } pldl_axil_req_t;

   typedef struct packed {
      logic        awready;
      logic        wready;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        arready;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
   } pldl_axil_rsp_t;

   // One edge-spacing measurement, in system clock cycles.
   typedef struct packed {
      logic       valid;
      logic [7:0] diff;
   } pldl_meas_t;

   // Longest time to whole cycles, rounded down, never below one cycle.
   function automatic logic [7:0] pldl_cyc_floor(input int ps);
      int c;
      c = ps / CLK_PERIOD_PS;
      if (c < 1) begin
         c = 1;
      end
      if (c > 255) begin
         c = 255;
      end
      return c[7:0];
   endfunction

endpackage

// ---- pldl_edge_meas.sv ----
// Measures the spacing between reference and feedback rising edges of each detector cycle.
`timescale 1ns/10ps
`default_nettype none
module pldl_edge_meas
   import pldl_pkg::*;
(
   input  wire logic       clk_sys,
   input  wire logic       srst,
   input  wire logic       ref_edge,
   input  wire logic       fb_edge,
   output var  pldl_meas_t meas
);

   typedef enum logic [1:0] {IDLE, REF_FIRST, FB_FIRST} pldl_meas_st_t;

   typedef struct packed {
      pldl_meas_st_t st;
      logic [7:0]    cnt;
      pldl_meas_t    meas;
   } pldl_meas_state_t;

   pldl_meas_state_t s;
   pldl_meas_state_t next_s;

   always_comb begin
      next_s            = s;
      next_s.meas.valid = 1'b0;
      if (s.cnt != DIFF_MAX) begin
         next_s.cnt = s.cnt + 8'h01;
      end
      case (s.st)
         IDLE: begin
            next_s.cnt = 8'h01;
            if (ref_edge && fb_edge) begin
               next_s.meas = '{valid: 1'b1, diff: 8'h00};
            end else if (ref_edge) begin
               next_s.st = REF_FIRST;
            end else if (fb_edge) begin
               next_s.st = FB_FIRST;
            end
         end
         REF_FIRST, FB_FIRST: begin
            // A repeated edge on the leading side means the other edge never came; report it as worst case.
            if ((s.st == REF_FIRST) ? fb_edge : ref_edge) begin
               next_s.meas = '{valid: 1'b1, diff: s.cnt};
               next_s.st   = IDLE;
               if ((s.st == REF_FIRST) ? ref_edge : fb_edge) begin
                  next_s.cnt = 8'h01;
                  next_s.st  = s.st;
               end
            end else if ((s.st == REF_FIRST) ? ref_edge : fb_edge) begin
               next_s.meas = '{valid: 1'b1, diff: DIFF_MAX};
               next_s.cnt  = 8'h01;
            end
         end
         default: begin
            next_s.st = IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         s <= '{st: IDLE, cnt: 8'h00, meas: '{valid: 1'b0, diff: 8'h00}};
      end else begin
         s <= next_s;
      end
   end

   assign meas = s.meas;

endmodule
`default_nettype wire

// ---- pldl_lock_detect.sv ----
// Digital lock detector of the loop's phase/frequency detector with its AXI4-Lite register file.
//
// Functional notes
// (RL1) Pulse code selects 2.9, 1.3, 6.0, 2.9 ns.
// (RL2) Config bit 7 enables reference dc offset.
// (RL3) Lock only after enough consecutive in-window cycles.
// (RL4) Counter code means 5, 16, 64, 255 cycles.
// (RL5) In-window means edge spacing below window time.
// (RL6) Lock holds until spacing exceeds loss threshold.
// (RL7) Window select resets to high range, 3.5 ns.
// (RL8) Out-of-window cycle restarts count before lock.
//
// The AXI4-Lite register port was decided locally.
`timescale 1ns/10ps
`default_nettype none
module pldl_lock_detect
   import pldl_pkg::*;
#(
   parameter int WIN_LOW_PS  = 1000,
   parameter int LOSS_PS     = 40000
)
(
   input  wire logic           clk_sys,
   input  wire logic           srst,
   input  wire pldl_axil_req_t axil_req,
   output var  pldl_axil_rsp_t axil_rsp,
   input  wire logic           ref_edge,
   input  wire logic           fb_edge,
   output logic                digital_lock_flag,
   output logic                dc_offset_en,
   output logic [15:0]         abl_pulse_ps,
   output logic                irq
);

   // Windows shorter than a clock period collapse to "same cycle", the finest spacing seen here.
   localparam logic [7:0] WIN_HIGH_CYC = pldl_cyc_floor(WIN_HIGH_PS);
   localparam logic [7:0] WIN_LOW_CYC  = pldl_cyc_floor(WIN_LOW_PS);
   localparam logic [7:0] LOSS_CYC     = pldl_cyc_floor(LOSS_PS);

   typedef struct packed {
      pldl_axil_rsp_t     rsp;
      logic               aw_hold;
      logic [AXIL_AW-1:0] aw_addr;
      logic               w_hold;
      logic [7:0]         w_data;
      logic               w_lane0;
      logic [7:0]         lcfg;
      logic [7:0]         pcfg;
      logic [1:0]         irq_stat;
      logic [1:0]         irq_mask;
      logic [7:0]         run_cnt;
      logic               lock_flag;
      logic               irq;
      logic [15:0]        abl_ps;
   } pldl_state_t;

   pldl_state_t s;
   pldl_state_t next_s;
   pldl_meas_t  meas;
   logic        wr_fire;
   logic        ev_lock;
   logic        ev_loss;
   logic [1:0]  irq_clr;
   logic [7:0]  win_cyc;
   logic [7:0]  target;
   logic        in_win;

   function automatic logic addr_mapped(input logic [AXIL_AW-1:0] a);
      return (a == ADDR_LOCK_CFG) || (a == ADDR_PULSE_CFG) || (a == ADDR_STATUS) ||
             (a == ADDR_IRQ_STAT) || (a == ADDR_IRQ_MASK);
   endfunction

   function automatic logic [15:0] abl_decode(input logic [1:0] code);
      case (code)
         2'h1:    return ABL_PS_1P3;
         2'h2:    return ABL_PS_6P0;
         default: return ABL_PS_2P9;
      endcase
   endfunction

   function automatic logic [7:0] run_target(input logic [1:0] code);
      case (code)
         2'h1:    return LOCK_RUN_16;
         2'h2:    return LOCK_RUN_64;
         2'h3:    return LOCK_RUN_255;
         default: return LOCK_RUN_5;
      endcase
   endfunction

   pldl_edge_meas u_meas (
      .clk_sys  (clk_sys),
      .srst     (srst),
      .ref_edge (ref_edge),
      .fb_edge  (fb_edge),
      .meas     (meas)
   );

   assign win_cyc = s.lcfg[LCFG_WIN_BIT] ? WIN_HIGH_CYC : WIN_LOW_CYC; // RL7
   assign target  = run_target(s.lcfg[LCFG_CNT_LSB +: 2]); // RL4
   assign in_win  = meas.diff < win_cyc; // RL5

   always_comb begin
      next_s  = s;
      ev_lock = 1'b0;
      ev_loss = 1'b0;
      irq_clr = 2'h0;
      wr_fire = s.aw_hold && s.w_hold && !s.rsp.bvalid;

      // Lock qualification runs only on finished measurements.
      if (meas.valid) begin
         if (in_win) begin
            if (!s.lock_flag) begin
               if (({1'b0, s.run_cnt} + 9'h001) >= {1'b0, target}) begin
                  next_s.lock_flag = 1'b1; // RL3
                  next_s.run_cnt   = 8'h00;
                  ev_lock          = 1'b1;
               end else begin
                  next_s.run_cnt = s.run_cnt + 8'h01;
               end
            end
         end else begin
            next_s.run_cnt = 8'h00; // RL8
            if (s.lock_flag && (meas.diff > LOSS_CYC)) begin
               next_s.lock_flag = 1'b0; // RL6
               ev_loss          = 1'b1;
            end
         end
      end

      // Write channel: address and data are taken independently, answered once both are held.
      if (axil_req.awvalid && s.rsp.awready) begin
         next_s.aw_hold = 1'b1;
         next_s.aw_addr = axil_req.awaddr;
      end
      if (axil_req.wvalid && s.rsp.wready) begin
         next_s.w_hold  = 1'b1;
         next_s.w_data  = axil_req.wdata[7:0];
         next_s.w_lane0 = axil_req.wstrb[0];
      end
      if (s.rsp.bvalid && axil_req.bready) begin
         next_s.rsp.bvalid = 1'b0;
      end
      if (wr_fire) begin
         next_s.aw_hold    = 1'b0;
         next_s.w_hold     = 1'b0;
         next_s.rsp.bvalid = 1'b1;
         next_s.rsp.bresp  = addr_mapped(s.aw_addr) ? RESP_OKAY : RESP_SLVERR;
         if (s.w_lane0) begin
            case (s.aw_addr)
               ADDR_LOCK_CFG:  next_s.lcfg     = s.w_data & LCFG_RW_MASK;
               ADDR_PULSE_CFG: next_s.pcfg     = s.w_data & PCFG_RW_MASK;
               ADDR_IRQ_STAT:  irq_clr         = s.w_data[1:0];
               ADDR_IRQ_MASK:  next_s.irq_mask = s.w_data[1:0];
               default:        next_s.irq_mask = s.irq_mask;
            endcase
         end
      end
      next_s.rsp.awready = !next_s.aw_hold && !next_s.rsp.bvalid;
      next_s.rsp.wready  = !next_s.w_hold && !next_s.rsp.bvalid;

      // A new event in the clearing cycle survives the clear.
      next_s.irq_stat = (s.irq_stat & ~irq_clr) | {ev_loss, ev_lock};
      next_s.irq      = |(next_s.irq_stat & next_s.irq_mask);

      // Read channel.
      if (s.rsp.rvalid && axil_req.rready) begin
         next_s.rsp.rvalid = 1'b0;
      end
      if (axil_req.arvalid && s.rsp.arready) begin
         next_s.rsp.rvalid = 1'b1;
         next_s.rsp.rresp  = addr_mapped(axil_req.araddr) ? RESP_OKAY : RESP_SLVERR;
         next_s.rsp.rdata  = 32'h0000_0000;
         case (axil_req.araddr)
            ADDR_LOCK_CFG:  next_s.rsp.rdata[7:0] = s.lcfg;
            ADDR_PULSE_CFG: next_s.rsp.rdata[7:0] = s.pcfg;
            ADDR_STATUS: begin
               next_s.rsp.rdata[0]                  = s.lock_flag;
               next_s.rsp.rdata[STAT_CNT_LSB +: 8]  = s.run_cnt;
            end
            ADDR_IRQ_STAT:  next_s.rsp.rdata[1:0] = s.irq_stat;
            ADDR_IRQ_MASK:  next_s.rsp.rdata[1:0] = s.irq_mask;
            default:        next_s.rsp.rdata      = 32'h0000_0000;
         endcase
      end
      next_s.rsp.arready = !next_s.rsp.rvalid;

      next_s.abl_ps = abl_decode(next_s.pcfg[PCFG_ABL_LSB +: 2]); // RL1
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         s              <= '0;
         s.rsp.awready  <= 1'b1;
         s.rsp.wready   <= 1'b1;
         s.rsp.arready  <= 1'b1;
         s.lcfg         <= LCFG_RESET; // RL7
         s.pcfg         <= PCFG_RESET;
         s.irq_stat     <= IRQ_RESET;
         s.irq_mask     <= IRQ_RESET;
         s.abl_ps       <= ABL_PS_2P9;
      end else begin
         s <= next_s;
      end
   end

   assign axil_rsp          = s.rsp;
   assign digital_lock_flag = s.lock_flag;
   assign dc_offset_en      = s.lcfg[LCFG_DC_OFS_BIT]; // RL2
   assign abl_pulse_ps      = s.abl_ps;
   assign irq               = s.irq;

   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (srst);

   AST_ABL_MAP: assert property ( // RL1
      ##1 (abl_pulse_ps == ((s.pcfg[PCFG_ABL_LSB +: 2] == 2'h1) ? ABL_PS_1P3 :
                            (s.pcfg[PCFG_ABL_LSB +: 2] == 2'h2) ? ABL_PS_6P0 : ABL_PS_2P9)))
      else $error("Antibacklash width does not match its code.");

   AST_DC_OFS: assert property ( // RL2
      (wr_fire && s.w_lane0 && (s.aw_addr == ADDR_LOCK_CFG)) |=> (dc_offset_en == $past(s.w_data[LCFG_DC_OFS_BIT])))
      else $error("Dc offset enable did not follow its config bit.");

   AST_LOCK_AFTER_RUN: assert property ( // RL3
      $rose(digital_lock_flag) |-> $past(meas.valid) && ($past(meas.diff) < $past(win_cyc)))
      else $error("Lock rose without an in-window detector cycle.");

   AST_LOCK_TARGET: assert property ( // RL4
      $rose(digital_lock_flag) |-> (({1'b0, $past(s.run_cnt)} + 9'h001) == {1'b0, $past(target)}))
      else $error("Lock rose at the wrong consecutive count.");

   AST_WIN_COUNTS: assert property ( // RL5
      (meas.valid && (meas.diff < win_cyc) && !s.lock_flag && ((s.run_cnt + 8'h01) < target))
      |=> (s.run_cnt == $past(s.run_cnt) + 8'h01))
      else $error("In-window cycle was not counted.");

   AST_LOCK_HOLD: assert property ( // RL6
      (s.lock_flag && !(meas.valid && (meas.diff > LOSS_CYC))) |=> s.lock_flag)
      else $error("Lock dropped without a loss-of-lock spacing.");

   AST_LOSS_DROP: assert property ( // RL6
      (s.lock_flag && meas.valid && (meas.diff > LOSS_CYC)) |=> !s.lock_flag ##0 s.irq_stat[IRQ_LOSS_BIT])
      else $error("Loss-of-lock spacing did not clear the lock.");

   AST_RESET_WIN: assert property ( // RL7
      disable iff (1'b0) srst |=> (s.lcfg[LCFG_WIN_BIT] && (win_cyc == WIN_HIGH_CYC)))
      else $error("Window select is not high range after reset.");

   AST_OUT_RESTART: assert property ( // RL8
      (meas.valid && !in_win && !s.lock_flag) |=> (s.run_cnt == 8'h00) [*1] ##1 !$rose(s.lock_flag))
      else $error("Out-of-window cycle did not restart the count.");

   AST_BRESP: assert property (
      (s.aw_hold && s.w_hold && !s.rsp.bvalid) |=> s.rsp.bvalid && !s.rsp.awready)
      else $error("Write response did not follow address and data.");

   COV_LOCK: cover property ($rose(digital_lock_flag));
   COV_LOSS: cover property ($fell(digital_lock_flag));
   COV_IRQ:  cover property ($rose(irq));
   COV_WR:   cover property (s.rsp.bvalid && axil_req.bready && (s.rsp.bresp == RESP_OKAY));

endmodule
`default_nettype wire

// ---- pldl_edge_src.sv ----
// Model of the reference and feedback divider paths feeding the detector edge inputs.
`timescale 1ns/10ps
`default_nettype none
module pldl_edge_src (
   input  wire logic       clk_sys,
   input  wire logic       srst,
   input  wire logic       start,
   input  wire logic [7:0] gap,
   output var  logic       ref_edge,
   output var  logic       fb_edge,
   output var  logic       busy
);
   logic [7:0] cnt;

   // The feedback edge trails the reference edge by gap cycles; a gap of zero puts both in one cycle.
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         ref_edge <= 1'b0;
         fb_edge  <= 1'b0;
         busy     <= 1'b0;
         cnt      <= 8'h00;
      end else begin
         ref_edge <= 1'b0;
         fb_edge  <= 1'b0;
         if (start && !busy) begin
            ref_edge <= 1'b1;
            fb_edge  <= (gap == 8'h00);
            busy     <= (gap != 8'h00);
            cnt      <= gap;
         end else if (busy) begin
            cnt <= cnt - 8'h01;
            if (cnt == 8'h01) begin
               fb_edge <= 1'b1;
               busy    <= 1'b0;
            end
         end
      end
   end
endmodule
`default_nettype wire

// ---- test_pldl_lock_detect.sv ----
// Self-checking testbench of the lock detector and its register file.
`timescale 1ns/10ps
`default_nettype none
module test_pldl_lock_detect;
   import pldl_pkg::*;
   localparam logic [15:0] ABL_TAB [4] = '{ABL_PS_2P9, ABL_PS_1P3, ABL_PS_6P0, ABL_PS_2P9};
   localparam logic [7:0]  RUN_TAB [4] = '{LOCK_RUN_5, LOCK_RUN_16, LOCK_RUN_64, LOCK_RUN_255};
   logic           clk_sys = 1'b0;
   logic           srst;
   pldl_axil_req_t req;
   pldl_axil_rsp_t rsp;
   logic           ref_edge;
   logic           fb_edge;
   logic           lock;
   logic           dc_ofs;
   logic [15:0]    abl;
   logic           irq;
   logic           start;
   logic [7:0]     gap;
   logic [33:0]    exp_q[$];
   int             errors = 0;
   int             tests_run = 0;
   int             c;
   int             i;

   always #10 clk_sys = ~clk_sys;

   pldl_lock_detect u_dut (
      .clk_sys          (clk_sys),
      .srst             (srst),
      .axil_req         (req),
      .axil_rsp         (rsp),
      .ref_edge         (ref_edge),
      .fb_edge          (fb_edge),
      .digital_lock_flag(lock),
      .dc_offset_en     (dc_ofs),
      .abl_pulse_ps     (abl),
      .irq              (irq)
   );

   pldl_edge_src u_src (
      .clk_sys (clk_sys),
      .srst    (srst),
      .start   (start),
      .gap     (gap),
      .ref_edge(ref_edge),
      .fb_edge (fb_edge),
      .busy    ()
   );

   task automatic test_done();
      if (errors == 0 && tests_run > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   task automatic report(input logic [33:0] e, input logic [33:0] g);
      tests_run++;
      if (g !== e) begin
         errors++;
         $display("wrong value at %0t: expected %h got %h", $time, e, g);
      end
   endtask

   task automatic check_bus(input logic [33:0] e, input logic [33:0] g);
      report(e, g);
   endtask

   task automatic check_pin(input logic [15:0] e, input logic [15:0] g);
      report({18'h0, e}, {18'h0, g});
   endtask

   task automatic hang();
      errors++;
      test_done();
   endtask

   // Both payloads are offered together and each is dropped at the edge where it is taken.
   task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] e);
      int n;
      exp_q.push_back({e, 32'h0});
      @(posedge clk_sys);
      req.awvalid <= 1'b1;
      req.awaddr  <= a;
      req.wvalid  <= 1'b1;
      req.wdata   <= d;
      req.wstrb   <= 4'hf;
      req.bready  <= 1'b1;
      for (n = 0; n < 50; n++) begin
         @(posedge clk_sys);
         if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
         if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
         if (rsp.bvalid) break;
      end
      req.bready <= 1'b0;
      if (n == 50) hang();
      @(posedge clk_sys);
      #1;
   endtask

   task automatic rd(input logic [11:0] a, input logic [33:0] e);
      int n;
      exp_q.push_back(e);
      @(posedge clk_sys);
      req.arvalid <= 1'b1;
      req.araddr  <= a;
      req.rready  <= 1'b1;
      for (n = 0; n < 50; n++) begin
         @(posedge clk_sys);
         if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
         if (rsp.rvalid) break;
      end
      req.rready <= 1'b0;
      if (n == 50) hang();
   endtask

   // One detector cycle; the wait covers the edge path and the two-edge lock latency.
   task automatic cyc(input logic [7:0] g);
      @(posedge clk_sys);
      start <= 1'b1;
      gap   <= g;
      @(posedge clk_sys);
      start <= 1'b0;
      repeat (int'(g) + 3) @(posedge clk_sys);
      #1;
   endtask

   always @(posedge clk_sys) begin
      if ((rsp.bvalid && req.bready) || (rsp.rvalid && req.rready)) begin
         check_bus(exp_q.pop_front(), rsp.bvalid ? {rsp.bresp, 32'h0} : {rsp.rresp, rsp.rdata});
      end
   end

   initial begin
      repeat (100000) @(posedge clk_sys);
      hang();
   end

   initial begin
      req   = '0;
      srst  = 1'b1;
      start = 1'b0;
      gap   = 8'h00;
      c     = $urandom(32'h6e77);
      repeat (16) @(posedge clk_sys);
      srst <= 1'b0;
      rd(ADDR_LOCK_CFG, {RESP_OKAY, 24'h0, LCFG_RESET});
      rd(ADDR_PULSE_CFG, {RESP_OKAY, 24'h0, PCFG_RESET});
      check_pin(ABL_PS_2P9, abl);
      check_pin(16'h0, {15'h0, dc_ofs});
      for (i = 0; i < 4; i++) begin
         wr(ADDR_PULSE_CFG, 32'(i), RESP_OKAY);
         check_pin(ABL_TAB[i], abl);
      end
      wr(ADDR_LOCK_CFG, 32'h90, RESP_OKAY);
      check_pin(16'h1, {15'h0, dc_ofs});
      rd(ADDR_LOCK_CFG, {RESP_OKAY, 32'h90});
      rd(12'h100, {RESP_SLVERR, 32'h0});
      wr(12'h104, 32'hff, RESP_SLVERR);
      wr(ADDR_IRQ_MASK, 32'h1, RESP_OKAY);
      for (c = 0; c < 4; c++) begin
         wr(ADDR_LOCK_CFG, {24'h0, 1'b0, 2'(c), 1'b1, 4'h0}, RESP_OKAY);
         check_pin(16'h0, {15'h0, dc_ofs});
         for (i = 1; i < int'(RUN_TAB[c]); i++) cyc(8'h00);
         // A random out-of-window spacing must throw away the run built so far.
         cyc(8'(1 + $urandom % 200));
         for (i = 1; i < int'(RUN_TAB[c]); i++) cyc(8'h00);
         check_pin(16'h0, {15'h0, lock});
         rd(ADDR_STATUS, {RESP_OKAY, 16'h0, RUN_TAB[c] - 8'h01, 8'h00});
         cyc(8'h00);
         check_pin(16'h1, {15'h0, lock});
         rd(ADDR_STATUS, {RESP_OKAY, 32'h1});
         check_pin(16'h1, {15'h0, irq});
         rd(ADDR_IRQ_STAT, {RESP_OKAY, 32'h1});
         wr(ADDR_IRQ_STAT, 32'h1, RESP_OKAY);
         repeat (2) @(posedge clk_sys);
         #1;
         check_pin(16'h0, {15'h0, irq});
         cyc(8'h02);
         check_pin(16'h1, {15'h0, lock});
         cyc(8'h03);
         check_pin(16'h0, {15'h0, lock});
         check_pin(16'h0, {15'h0, irq});
         rd(ADDR_IRQ_STAT, {RESP_OKAY, 32'h2});
         wr(ADDR_IRQ_STAT, 32'h2, RESP_OKAY);
      end
      // The low-range window still admits same-cycle edges at this clock rate.
      wr(ADDR_LOCK_CFG, 32'h0, RESP_OKAY);
      for (i = 0; i < int'(LOCK_RUN_5); i++) cyc(8'h00);
      check_pin(16'h1, {15'h0, lock});
      rd(ADDR_STATUS, {RESP_OKAY, 32'h1});
      repeat (4) @(posedge clk_sys);
      test_done();
   end
endmodule
`default_nettype wire
